// ===== verilog/csp_counter_sync.sv
// module: position counter with reference-edge synchronisation and images
`timescale 1ns/10ps
`default_nettype none
module csp_counter_sync import csp_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire csp_di_fn_t di_function,
  input wire logic sync_periodic,
  input wire logic iso_mode,
  input wire csp_ctrl_t ctrl_image,
  input wire logic ctrl_valid,
  input wire logic sample_instant,
  input wire logic reference_input,
  input wire logic count_up_pulse,
  input wire logic count_down_pulse,
  input wire logic encoder_supply_fault_in,
  output csp_fb_t fb_image,
  output logic fb_valid
);

  // ==========================================================================
  // pin synchronisers and edge detection
  logic [3:0] pins_raw;
  logic [3:0] pins_s;
  logic [3:0] pins_d_r;
  logic ref_lvl;
  logic ref_rise;
  logic up_ev;
  logic dn_ev;
  logic fault_lvl;

  assign pins_raw = {encoder_supply_fault_in, count_down_pulse,
                     count_up_pulse, reference_input};

  csp_sync2 #(.W(CSP_PIN_COUNT)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  // delayed copy of the synchronised pins for edge finding
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_d_r <= '0;
    end else begin
      pins_d_r <= pins_s;
    end
  end

  assign ref_lvl = pins_s[0];
  assign ref_rise = pins_s[0] & ~pins_d_r[0];
  assign up_ev = pins_s[1] & ~pins_d_r[1];
  assign dn_ev = pins_s[2] & ~pins_d_r[2];
  assign fault_lvl = pins_s[3];

  // ==========================================================================
  // control image capture
  csp_ctrl_t ctrl_r;
  csp_ctrl_t ctrl_nxt;
  logic gate_rise;
  logic ack_rise;
  logic pre_rise;
  logic dir_rise;
  logic multi_req;

  // the whole image is taken in one cycle so no group tears
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_valid) begin
      ctrl_nxt = ctrl_image;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // edges of control bits, judged against the previous transfer
  assign gate_rise = ctrl_valid & ctrl_image.gate_sync_ack[CTL_SOFTWARE_GATE_CTL]
                     & ~ctrl_r.gate_sync_ack[CTL_SOFTWARE_GATE_CTL];
  assign ack_rise = ctrl_valid & ctrl_image.gate_sync_ack[CTL_ERR_ACK]
                    & ~ctrl_r.gate_sync_ack[CTL_ERR_ACK];
  assign pre_rise = ctrl_valid & ctrl_image.load_req[CTL_PRELOAD]
                    & ~ctrl_r.load_req[CTL_PRELOAD];
  assign dir_rise = ctrl_valid & ctrl_image.load_req[CTL_DIRECT]
                    & ~ctrl_r.load_req[CTL_DIRECT];
  // both load requests in one transfer is refused outright
  assign multi_req = (pre_rise | dir_rise) & ctrl_image.load_req[CTL_PRELOAD]
                     & ctrl_image.load_req[CTL_DIRECT];

  // ==========================================================================
  // gates
  logic software_gate_ctl_r;
  logic software_gate_ctl_nxt;
  logic hw_gate;
  logic int_gate;

  // only a positive edge opens; a clear bit closes one cycle after its transfer
  always_comb begin
    software_gate_ctl_nxt = software_gate_ctl_r;
    if (gate_rise) begin
      software_gate_ctl_nxt = 1'b1;
    end else if (!ctrl_r.gate_sync_ack[CTL_SOFTWARE_GATE_CTL]) begin
      software_gate_ctl_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      software_gate_ctl_r <= 1'b0;
    end else begin
      software_gate_ctl_r <= software_gate_ctl_nxt;
    end
  end

  assign hw_gate = (di_function == DI_HW_GATE) ? ref_lvl : 1'b1;
  assign int_gate = software_gate_ctl_r & hw_gate;

  // ==========================================================================
  // synchronisation state machine
  csp_sync_st_t sync_st_r;
  csp_sync_st_t sync_st_nxt;
  logic sync_en;
  logic sync_hit;

  assign sync_en = ctrl_r.gate_sync_ack[CTL_SYNC_EN];

  // arming waits for the enable so an edge before it never counts
  always_comb begin
    sync_st_nxt = sync_st_r;
    sync_hit = 1'b0;
    case (sync_st_r)
      SYNC_OFF: begin
        if (sync_en && di_function == DI_SYNC) begin
          sync_st_nxt = SYNC_ARMED;
        end
      end
      SYNC_ARMED: begin
        if (!sync_en || di_function != DI_SYNC) begin
          sync_st_nxt = SYNC_OFF;
        end else if (ref_rise && software_gate_ctl_r) begin
          sync_hit = 1'b1;
          if (!sync_periodic) begin
            sync_st_nxt = SYNC_SPENT;
          end else begin
            sync_st_nxt = SYNC_ARMED;
          end
        end
      end
      SYNC_SPENT: begin
        if (!sync_en) begin
          sync_st_nxt = SYNC_OFF;
        end
      end
      default: begin
        sync_st_nxt = SYNC_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_st_r <= SYNC_OFF;
    end else begin
      sync_st_r <= sync_st_nxt;
    end
  end

  // ==========================================================================
  // counter, load value and latch
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] load_r;
  logic [31:0] load_nxt;
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  logic up_r;
  logic up_nxt;
  logic dn_r;
  logic dn_nxt;
  logic step_up;
  logic step_dn;
  logic ev_high;
  logic ev_low;
  logic ev_zero;

  // simultaneous up and down pulses cancel
  assign step_up = int_gate & up_ev & ~dn_ev;
  assign step_dn = int_gate & dn_ev & ~up_ev;
  // the two's complement wrap is the limit jump
  assign ev_high = step_up & (count_r == CSP_HIGH_LIMIT);
  assign ev_low = step_dn & (count_r == CSP_LOW_LIMIT);
  assign ev_zero = (step_up & (count_r == 32'hffff_ffff))
                   | (step_dn & (count_r == 32'h0000_0000));

  // direct load beats a reload, which beats a count step
  always_comb begin
    count_nxt = count_r;
    load_nxt = load_r;
    latch_nxt = latch_r;
    up_nxt = up_r;
    dn_nxt = dn_r;
    if (pre_rise && !multi_req) begin
      load_nxt = ctrl_image.operand;
    end
    if (dir_rise && !multi_req) begin
      count_nxt = ctrl_image.operand;
    end else if (sync_hit) begin
      count_nxt = load_r;
    end else if (step_up) begin
      count_nxt = count_r + 32'h0000_0001;
      up_nxt = 1'b1;
      dn_nxt = 1'b0;
    end else if (step_dn) begin
      count_nxt = count_r - 32'h0000_0001;
      up_nxt = 1'b0;
      dn_nxt = 1'b1;
    end
    // latch input stays live even with the gate closed
    if (di_function == DI_LATCH && ref_rise) begin
      latch_nxt = count_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_r <= CSP_COUNT_RST;
      load_r <= CSP_LOAD_RST;
      latch_r <= CSP_LATCH_RST;
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      load_r <= load_nxt;
      latch_r <= latch_nxt;
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  // ==========================================================================
  // status, error and handshake flags
  logic rst_act_r;
  logic rst_act_nxt;
  logic sync_done_r;
  logic sync_done_nxt;
  logic zero_r;
  logic zero_nxt;
  logic low_r;
  logic low_nxt;
  logic high_r;
  logic high_nxt;
  logic supply_err_r;
  logic supply_err_nxt;
  logic load_err_r;
  logic load_err_nxt;
  logic param_err_r;
  logic param_err_nxt;
  logic busy_r;
  logic busy_nxt;
  logic clr;

  // clearing lasts while the request stands; a same-cycle set wins
  assign clr = rst_act_r;

  always_comb begin
    rst_act_nxt = ctrl_r.gate_sync_ack[CTL_STS_RST];
    sync_done_nxt = sync_hit | (sync_done_r & ~clr);
    zero_nxt = ev_zero | (zero_r & ~clr);
    low_nxt = ev_low | (low_r & ~clr);
    high_nxt = ev_high | (high_r & ~clr);
    // supply and load errors drop only on an acknowledge once the cause is gone
    supply_err_nxt = fault_lvl | (supply_err_r & ~(ack_rise & ~fault_lvl));
    load_err_nxt = multi_req | (load_err_r & ~ack_rise);
    param_err_nxt = di_function > DI_SYNC;
    busy_nxt = (ctrl_r.load_req[CTL_PRELOAD] | ctrl_r.load_req[CTL_DIRECT])
               & ~load_err_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_act_r <= 1'b0;
      sync_done_r <= 1'b0;
      zero_r <= 1'b0;
      low_r <= 1'b0;
      high_r <= 1'b0;
      supply_err_r <= 1'b0;
      load_err_r <= 1'b0;
      param_err_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      rst_act_r <= rst_act_nxt;
      sync_done_r <= sync_done_nxt;
      zero_r <= zero_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
      supply_err_r <= supply_err_nxt;
      load_err_r <= load_err_nxt;
      param_err_r <= param_err_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================================
  // feedback image assembly and snapshot
  logic [7:0] err_bits;
  logic [7:0] dir_bits;
  logic [7:0] sticky_bits;
  csp_fb_t fb_pack;
  csp_fb_t fb_r;
  csp_fb_t fb_nxt;
  logic fb_valid_r;
  logic fb_valid_nxt;
  logic snap;

  // reserved bits tie to zero
  always_comb begin
    err_bits = 8'h00;
    err_bits[FB_SUPPLY] = supply_err_r;
    err_bits[FB_PARAM] = param_err_r;
    err_bits[FB_RST_ACT] = rst_act_r;
    err_bits[FB_LOAD_ERR] = load_err_r;
    err_bits[FB_LOAD_BUSY] = busy_r;
    dir_bits = 8'h00;
    dir_bits[FB_DOWN] = dn_r;
    dir_bits[FB_UP] = up_r;
    dir_bits[FB_LEVEL] = ref_lvl;
    dir_bits[FB_GATE] = int_gate;
    sticky_bits = 8'h00;
    sticky_bits[FB_ZERO] = zero_r;
    sticky_bits[FB_LOW] = low_r;
    sticky_bits[FB_HIGH] = high_r;
    sticky_bits[FB_SYNC] = sync_done_r;
  end

  csp_fb_pack u_pack (
    .count(count_r),
    .latch(latch_r),
    .use_latch(di_function == DI_LATCH),
    .err_bits(err_bits),
    .dir_bits(dir_bits),
    .sticky_bits(sticky_bits),
    .image(fb_pack)
  );

  // isochrone: one snapshot per sample instant, so a set sync flag
  // covers edges since the previous instant; otherwise every cycle
  assign snap = ~iso_mode | sample_instant;

  always_comb begin
    fb_nxt = fb_r;
    fb_valid_nxt = 1'b0;
    if (snap) begin
      fb_nxt = fb_pack;
      fb_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fb_r <= '0;
      fb_valid_r <= 1'b0;
    end else begin
      fb_r <= fb_nxt;
      fb_valid_r <= fb_valid_nxt;
    end
  end

  assign fb_image = fb_r;
  assign fb_valid = fb_valid_r;

endmodule
`default_nettype wire

// ===== verilog/csp_pkg.sv
// package: constants, image layouts and enums for the counter sync block
// ==========================================================================
// Overview of operation
// - rising reference edge reloads counter with load value
// - once-only or periodic variant chosen by parameter
// - no reload before software gate opened counting
// - sync_enable must be set, else edges ignored
// - once-only: only first edge after enable reloads
// - periodic: first and every later edge reload
// - sync_done_flag sticky until status reset handshake
// - input_level_flag follows reference input level
// - isochrone: flag means edge between sample instants
// - byte groups 0-3, 4-7, 8-11 move as units
// - bytes 0-3: count, or latched count if latch
// - feedback byte 4 error and load bits
// - status bits cleared by request/active handshake
// - error bits kept until acknowledged after cause gone; parameter error bit not kept, follows di_function
// - several load requests at once: reject, flag error
package csp_pkg;

  // ==========================================================================
  // widths and byte offsets of the process images
  localparam int CSP_CW = 32;
  localparam int CSP_OFS_VALUE = 0;
  localparam int CSP_OFS_BYTE4 = 4;
  localparam int CSP_OFS_BYTE5 = 5;
  localparam int CSP_OFS_BYTE6 = 6;
  localparam int CSP_OFS_BYTE7 = 7;
  localparam int CSP_OFS_CURRENT = 8;

  // ==========================================================================
  // control image bit positions
  localparam int CTL_ERR_ACK = 7;
  localparam int CTL_STS_RST = 2;
  localparam int CTL_SYNC_EN = 1;
  localparam int CTL_SOFTWARE_GATE_CTL = 0;
  localparam int CTL_PRELOAD = 1;
  localparam int CTL_DIRECT = 0;

  // ==========================================================================
  // feedback image bit positions
  localparam int FB_SUPPLY = 7;
  localparam int FB_PARAM = 5;
  localparam int FB_RST_ACT = 2;
  localparam int FB_LOAD_ERR = 1;
  localparam int FB_LOAD_BUSY = 0;
  localparam int FB_DOWN = 7;
  localparam int FB_UP = 6;
  localparam int FB_LEVEL = 1;
  localparam int FB_GATE = 0;
  localparam int FB_ZERO = 7;
  localparam int FB_LOW = 6;
  localparam int FB_HIGH = 5;
  localparam int FB_SYNC = 0;

  // ==========================================================================
  // values after parameter-assignment reset and limits
  localparam logic [31:0] CSP_LOAD_RST = 32'h0000_0000;
  localparam logic [31:0] CSP_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] CSP_LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] CSP_HIGH_LIMIT = 32'h7fff_ffff;
  localparam logic [31:0] CSP_LOW_LIMIT = 32'h8000_0000;
  localparam int CSP_PIN_COUNT = 4;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    DI_INPUT = 3'b000,
    DI_HW_GATE = 3'b001,
    DI_LATCH = 3'b010,
    DI_SYNC = 3'b011
  } csp_di_fn_t;

  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_ARMED = 2'b01,
    SYNC_SPENT = 2'b10
  } csp_sync_st_t;

  typedef struct packed {
    logic [31:0] operand;
    logic [7:0] gate_sync_ack;
    logic [7:0] load_req;
    logic [15:0] tail;
  } csp_ctrl_t;

  typedef struct packed {
    logic [31:0] count_value;
    logic [7:0] error_load;
    logic [7:0] dir_gate;
    logic [7:0] sticky;
    logic [7:0] rsvd;
    logic [31:0] current_count;
  } csp_fb_t;

endpackage

// ===== verilog/csp_sync2.sv
// module: two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module csp_sync2 import csp_pkg::*; #(
  parameter int W = CSP_PIN_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;
endmodule
`default_nettype wire

// ===== verilog/csp_fb_pack.sv
// module: packs block state into the feedback image layout
`timescale 1ns/10ps
`default_nettype none
module csp_fb_pack import csp_pkg::*; (
  input wire logic [31:0] count,
  input wire logic [31:0] latch,
  input wire logic use_latch,
  input wire logic [7:0] err_bits,
  input wire logic [7:0] dir_bits,
  input wire logic [7:0] sticky_bits,
  output csp_fb_t image
);
  // byte 7 always zero; bytes 8-11 always the live count
  always_comb begin
    image = '0;
    image.count_value = use_latch ? latch : count;
    image.error_load = err_bits;
    image.dir_gate = dir_bits;
    image.sticky = sticky_bits;
    image.rsvd = 8'h00;
    image.current_count = count;
  end
endmodule
`default_nettype wire

// ===== sim/csp_counter_sync_properties.sv
// checker: port-level properties of the counter sync block
`timescale 1ns/10ps
`default_nettype none
module csp_counter_sync_chk import csp_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire csp_di_fn_t di_function,
  input wire logic iso_mode,
  input wire csp_ctrl_t ctrl_image,
  input wire logic ctrl_valid,
  input wire logic sample_instant,
  input wire logic reference_input,
  input wire logic encoder_supply_fault_in,
  input wire csp_fb_t fb_image,
  input wire logic fb_valid
);
  logic [1:0] last_req_r;
  logic [1:0] last_req_nxt;

  // ==========================================================================
  // helper: last taken request pair, a rise is judged against it
  always_comb begin
    last_req_nxt = ctrl_valid ? ctrl_image.load_req[1:0] : last_req_r;
  end
  always_ff @(posedge clk) begin
    last_req_r <= reset_n ? last_req_nxt : 2'h0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_reserved_zero;
    fb_image.rsvd == 8'h00 && (fb_image.error_load & 8'h58) == 8'h00 &&
      (fb_image.dir_gate & 8'h3c) == 8'h00 && (fb_image.sticky & 8'h1e) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved image bit set");
  // five cycles cover two sync stages plus the image register
  property p_level;
    (!iso_mode && $stable(reference_input))[*5] |->
      fb_image.dir_gate[FB_LEVEL] == reference_input;
  endproperty
  a_level: assert property (p_level)
    else $error("level flag differs from input");
  property p_supply;
    (!iso_mode && encoder_supply_fault_in)[*5] |-> fb_image.error_load[FB_SUPPLY];
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply fault not shown");
  property p_copy_count;
    !$past(iso_mode) && $past(di_function) != DI_LATCH |->
      fb_image.count_value == fb_image.current_count;
  endproperty
  a_copy_count: assert property (p_copy_count)
    else $error("count groups disagree");
  property p_iso_valid;
    iso_mode |=> fb_valid == $past(sample_instant);
  endproperty
  a_iso_valid: assert property (p_iso_valid)
    else $error("refresh off the sample instant");
  property p_iso_hold;
    iso_mode && !sample_instant |=> $stable(fb_image);
  endproperty
  a_iso_hold: assert property (p_iso_hold)
    else $error("image moved between instants");
  property p_status_ack;
    ctrl_valid && ctrl_image.gate_sync_ack[CTL_STS_RST] ##1 (!iso_mode && !ctrl_valid)[*4]
      |-> fb_image.error_load[FB_RST_ACT];
  endproperty
  a_status_ack: assert property (p_status_ack)
    else $error("status reset not answered");
  // the sync flag may only drop while the reset handshake is shown
  property p_sync_hold;
    $past(reset_n) && !$past(iso_mode) && !$past(iso_mode, 2) &&
      $fell(fb_image.sticky[FB_SYNC]) |->
      fb_image.error_load[FB_RST_ACT] || $past(fb_image.error_load[FB_RST_ACT]);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync flag lost without reset");
  property p_load_err;
    ctrl_valid && ctrl_image.load_req[1:0] == 2'h3 && last_req_r != 2'h3 ##1
      (!iso_mode && !ctrl_valid)[*3] |-> fb_image.error_load[FB_LOAD_ERR];
  endproperty
  a_load_err: assert property (p_load_err)
    else $error("double request not flagged");
endmodule

bind csp_counter_sync csp_counter_sync_chk chk (.clk(clk), .reset_n(reset_n),
  .di_function(di_function), .iso_mode(iso_mode), .ctrl_image(ctrl_image),
  .ctrl_valid(ctrl_valid), .sample_instant(sample_instant),
  .reference_input(reference_input), .encoder_supply_fault_in(encoder_supply_fault_in),
  .fb_image(fb_image), .fb_valid(fb_valid));
`default_nettype wire

// ===== sim/csp_bus_master.sv
// partner: fieldbus master model exchanging control and feedback images
`timescale 1ns/10ps
`default_nettype none
module csp_bus_master import csp_pkg::*; (
  input wire logic clk,
  input wire csp_fb_t fb_image,
  input wire logic fb_valid,
  output var csp_ctrl_t ctrl_image,
  output var logic ctrl_valid,
  output var csp_fb_t fb_last
);
  // ==========================================================================
  // cyclic exchange
  initial begin
    ctrl_image = '0;
    ctrl_valid = 1'b0;
    fb_last = '0;
  end

  // keep whole snapshots only; a mixed image would pair stale counts
  always @(posedge clk) begin
    if (fb_valid) begin
      fb_last <= fb_image;
    end
  end

  // one bus cycle; reserved bits go out as zero, image stands afterwards
  task automatic send(input logic [31:0] op, input logic [7:0] b4, input logic [7:0] b5);
    @(negedge clk);
    ctrl_image = '{op, b4 & 8'h87, b5 & 8'h03, 16'h0000};
    ctrl_valid = 1'b1;
    @(negedge clk);
    ctrl_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_counter_sync_and_process_image.sv
// testbench: sync reload, image layout and handshakes of the counter
`timescale 1ns/10ps
`default_nettype none
module tb_counter_sync_and_process_image import csp_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  csp_di_fn_t di_function = DI_SYNC;
  logic sync_periodic = 1'b0;
  logic iso_mode = 1'b0;
  logic sample_instant = 1'b0;
  logic ref_in = 1'b0;
  logic up_pulse = 1'b0;
  logic dn_pulse = 1'b0;
  logic supply_fault = 1'b0;
  logic ctrl_valid;
  logic fb_valid;
  csp_ctrl_t ctrl_image;
  csp_fb_t fb_image;
  csp_fb_t fb;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  // ==========================================================================
  // clock, design and bus partner
  always #5 clk = ~clk;

  csp_counter_sync dut (.clk(clk), .reset_n(reset_n), .di_function(di_function),
    .sync_periodic(sync_periodic), .iso_mode(iso_mode), .ctrl_image(ctrl_image),
    .ctrl_valid(ctrl_valid), .sample_instant(sample_instant), .reference_input(ref_in),
    .count_up_pulse(up_pulse), .count_down_pulse(dn_pulse),
    .encoder_supply_fault_in(supply_fault), .fb_image(fb_image), .fb_valid(fb_valid));
  csp_bus_master m (.clk(clk), .fb_image(fb_image), .fb_valid(fb_valid),
    .ctrl_image(ctrl_image), .ctrl_valid(ctrl_valid), .fb_last(fb));

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // transfer, then let sync stages and the image settle
  task automatic send(input logic [31:0] op, input logic [7:0] b4, input logic [7:0] b5);
    m.send(op, b4, b5);
    repeat (5) @(negedge clk);
  endtask

  task automatic pulse_ref();
    ref_in = 1'b1;
    repeat (8) @(negedge clk);
    check(32'(fb.dir_gate[FB_LEVEL]), 32'h1);
    ref_in = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic sample();
    sample_instant = 1'b1;
    @(negedge clk);
    sample_instant = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // ==========================================================================
  // tests
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    // operand lands whole in both count groups, then a preload of 0x100
    send(32'h1234_5678, 8'h00, 8'h01);
    check(fb.current_count, 32'h1234_5678);
    check(fb.count_value, 32'h1234_5678);
    check(32'(fb.rsvd), 32'h0);
    send(32'h0000_0100, 8'h00, 8'h02);
    send(32'h0, 8'h02, 8'h00);
    pulse_ref();
    check(fb.current_count, 32'h1234_5678);
    send(32'h1234_5678, 8'h01, 8'h01);
    send(32'h0, 8'h01, 8'h00);
    pulse_ref();
    check(fb.current_count, 32'h1234_5678);
    $display("test gating done");
    // once-only: a second edge must not reload
    send(32'h0, 8'h03, 8'h00);
    pulse_ref();
    check(fb.current_count, 32'h0000_0100);
    check(32'(fb.sticky[FB_SYNC]), 32'h1);
    check(32'(fb.dir_gate[FB_GATE]), 32'h1);
    send(32'h55, 8'h03, 8'h01);
    send(32'h0, 8'h03, 8'h00);
    pulse_ref();
    check(fb.current_count, 32'h55);
    check(32'(fb.sticky[FB_SYNC]), 32'h1);
    $display("test once-only done");
    // periodic: every edge reloads
    sync_periodic = 1'b1;
    send(32'h0, 8'h01, 8'h00);
    send(32'h0, 8'h03, 8'h00);
    for (int i = 0; i < 2; i++) begin
      send(32'h55, 8'h03, 8'h01);
      send(32'h0, 8'h03, 8'h00);
      pulse_ref();
      check(fb.current_count, 32'h0000_0100);
    end
    $display("test periodic done");
    // status reset handshake clears the sync flag
    send(32'h0, 8'h07, 8'h00);
    check(32'(fb.error_load[FB_RST_ACT]), 32'h1);
    check(32'(fb.sticky[FB_SYNC]), 32'h0);
    send(32'h0, 8'h03, 8'h00);
    check(32'(fb.error_load[FB_RST_ACT]), 32'h0);
    // double load request is refused and kept until acknowledged
    send(32'h999, 8'h03, 8'h03);
    check(fb.current_count, 32'h0000_0100);
    check(32'(fb.error_load[FB_LOAD_ERR]), 32'h1);
    send(32'h0, 8'h03, 8'h00);
    check(32'(fb.error_load[FB_LOAD_ERR]), 32'h1);
    send(32'h0, 8'h83, 8'h00);
    check(32'(fb.error_load[FB_LOAD_ERR]), 32'h0);
    // supply fault survives an acknowledge while the cause remains
    supply_fault = 1'b1;
    send(32'h0, 8'h03, 8'h00);
    check(32'(fb.error_load[FB_SUPPLY]), 32'h1);
    send(32'h0, 8'h83, 8'h00);
    check(32'(fb.error_load[FB_SUPPLY]), 32'h1);
    supply_fault = 1'b0;
    send(32'h0, 8'h03, 8'h00);
    send(32'h0, 8'h83, 8'h00);
    check(32'(fb.error_load[FB_SUPPLY]), 32'h0);
    $display("test errors done");
    up_pulse = 1'b1;
    repeat (4) @(negedge clk);
    up_pulse = 1'b0;
    repeat (4) @(negedge clk);
    check(fb.current_count, 32'h0000_0101);
    check(32'(fb.dir_gate[FB_UP]), 32'h1);
    // isochrone: the edge shows only after the next sample instant
    iso_mode = 1'b1;
    sample();
    ref_in = 1'b1;
    repeat (8) @(negedge clk);
    ref_in = 1'b0;
    repeat (4) @(negedge clk);
    check(fb_image.current_count, 32'h0000_0101);
    check(32'(fb_image.sticky[FB_SYNC]), 32'h0);
    sample();
    check(fb.current_count, 32'h0000_0100);
    check(32'(fb.sticky[FB_SYNC]), 32'h1);
    $display("test isochrone done");
    iso_mode = 1'b0;
    // one down edge steps back and flips the direction flags
    dn_pulse = 1'b1;
    repeat (4) @(negedge clk);
    dn_pulse = 1'b0;
    repeat (4) @(negedge clk);
    check(fb.current_count, 32'h0000_00ff);
    check(32'(fb.dir_gate[FB_DOWN]), 32'h1);
    check(32'(fb.dir_gate[FB_UP]), 32'h0);
    // latch: bytes 0-3 keep the edge count while the live count moves on
    di_function = DI_LATCH;
    pulse_ref();
    up_pulse = 1'b1;
    repeat (4) @(negedge clk);
    up_pulse = 1'b0;
    repeat (4) @(negedge clk);
    check(fb.count_value, 32'h0000_00ff);
    check(fb.current_count, 32'h0000_0100);
    // hardware gate follows the low reference level and closes
    di_function = DI_HW_GATE;
    repeat (5) @(negedge clk);
    check(32'(fb.dir_gate[FB_GATE]), 32'h0);
    $display("test latch and gate done");
    di_function = csp_di_fn_t'(3'h5);
    repeat (5) @(negedge clk);
    check(32'(fb.error_load[FB_PARAM]), 32'h1);
    $display("test parameter done");
    conclude();
  end
endmodule
`default_nettype wire
